// *** logic/synth_pkg.sv ***
/*
 * shared constants, types and decode functions for the synthesizer mode
 * selection and single-tone core.
 * assumes a 32-bit apb register bus with one aligned word per register.
 */
`default_nettype none
package synth_pkg;
    // datapath widths
    localparam int ACC_W  = 48;
    localparam int AMP_W  = 12;
    localparam int PHS_W  = 14;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int HI_W   = ACC_W - DATA_W;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_TW1_LO = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_TW1_HI = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_TW2_LO = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_TW2_HI = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_AMPL   = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_PADJ1  = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_PADJ2  = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h20;

    // control register fields
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_MODE_W    = 3;
    localparam int CTRL_LSBF_BIT  = 3;
    localparam int CTRL_RBDED_BIT = 4;
    // status register fields
    localparam int STAT_MODE_LSB  = 0;
    localparam int STAT_PAR_BIT   = 5;
    localparam int STAT_DIFF_BIT  = 6;
    localparam int STAT_CAPS_LSB  = 8;

    // mode field codes
    localparam logic [2:0] CODE_SINGLE = 3'h0;
    localparam logic [2:0] CODE_FSK    = 3'h1;
    localparam logic [2:0] CODE_RFSK   = 3'h2;
    localparam logic [2:0] CODE_CHIRP  = 3'h3;
    localparam logic [2:0] CODE_BPSK   = 3'h4;

    // reset values and fixed codes
    localparam logic [ACC_W-1:0]  TW_RST    = 48'h0000_0000_0000;
    localparam logic [AMP_W-1:0]  AMPL_RST  = 12'h000;
    localparam logic [PHS_W-1:0]  PADJ_RST  = 14'h0000;
    localparam logic [AMP_W-1:0]  DAC_MID   = 12'h800;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [4:0] {
        MODE_SINGLE = 5'h01,
        MODE_FSK    = 5'h02,
        MODE_RFSK   = 5'h04,
        MODE_CHIRP  = 5'h08,
        MODE_BPSK   = 5'h10
    } mode_t;

    // function availability per mode
    typedef struct packed {
        logic sweep;
        logic tw2;
        logic tw1;
        logic inv_sinc;
        logic ampl;
        logic phase_mod;
        logic pin_keying;
        logic pin_fsk;
        logic padj2;
        logic padj1;
    } caps_t;

    // undefined codes fall back to single tone
    function automatic mode_t decode_mode(input logic [2:0] code);
        case (code)
            CODE_FSK:   decode_mode = MODE_FSK;
            CODE_RFSK:  decode_mode = MODE_RFSK;
            CODE_CHIRP: decode_mode = MODE_CHIRP;
            CODE_BPSK:  decode_mode = MODE_BPSK;
            default:    decode_mode = MODE_SINGLE;
        endcase
    endfunction

    function automatic caps_t mode_caps(input mode_t m);
        caps_t c;
        c = '0;
        c.padj1      = 1'b1;
        c.pin_keying = 1'b1;
        c.ampl       = 1'b1;
        c.inv_sinc   = 1'b1;
        c.tw1        = 1'b1;
        c.phase_mod  = (m != MODE_BPSK);
        c.padj2      = (m == MODE_BPSK);
        c.pin_fsk    = (m != MODE_SINGLE);
        c.tw2        = (m == MODE_FSK) || (m == MODE_RFSK);
        c.sweep      = (m == MODE_RFSK) || (m == MODE_CHIRP);
        mode_caps = c;
    endfunction
endpackage
`default_nettype wire

// *** logic/tune_if.sv ***
/*
 * carries the chosen tuning word into the phase core and the top phase
 * bits back out.
 * assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface tune_if;
    import synth_pkg::*;
    logic [ACC_W-1:0] tuning_word;
    logic [PHS_W-1:0] phase_top;
    modport ctrl (output tuning_word, input phase_top);
    modport core (input tuning_word, output phase_top);
endinterface
`default_nettype wire

// *** logic/phase_core.sv ***
/*
 * phase accumulator: adds the tuning word every clock and offers the top
 * phase bits.
 * assumes the tuning word is registered by the controlling module.
 */
`timescale 1ns/1ps
`default_nettype none
module phase_core import synth_pkg::*; #(
    parameter int W = ACC_W
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // tuning side
    tune_if.core     tun
);
    typedef struct packed {
        logic [W-1:0] acc;
    } core_st_t;

    core_st_t st_q;
    core_st_t st_d;

    if (W < PHS_W || W > ACC_W) begin : g_chk
        $error("phase_core: accumulator width out of range");
    end

    // never cleared on a new word, so a retune keeps its phase
    always_comb begin
        st_d = st_q;
        st_d.acc = st_q.acc + tun.tuning_word[W-1:0];
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_q <= '0; // zero phase out of reset
        end else begin
            st_q <= st_d;
        end
    end

    assign tun.phase_top = st_q.acc[W-1 -: PHS_W];

    a_phase_continuous: assert property (@(posedge CLK) disable iff (SYS_RST)
        st_q.acc == $past(st_q.acc) + $past(tun.tuning_word[W-1:0]))
        else $error("accumulator did not continue from last phase");
endmodule
`default_nettype wire

// *** logic/synth_mode_select_single_tone.sv ***
/*
 * mode selection and single-tone core of a direct digital synthesizer:
 * apb register file, interface and reference clock selection, five-mode
 * decode with function gating, tuning word choice and dac codes.
 * assumes a synchronous apb master on CLK and pins synchronous to CLK.
 */
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - parallel interface when select pin high, serial interface when low
// - bit-order bit set loads serial words lsb first, clear msb first
// - readback bit set drives readback data only on dedicated serial out
// - readback bit clear: data pin bidirectional, dedicated pin unused
// - bit-order and readback bits are ignored in parallel interface mode
// - mode field decodes single-tone, fsk, ramped fsk, chirp, bpsk
// - single-tone after reset and whenever software writes its code
// - single-tone feeds accumulator from tuning word one, reset zero
// - after reset 0 Hz, zero phase, both dacs at midscale
// - frequency change keeps accumulator phase, no reset
// - output frequency is word times clock over two to the 48th
// - 48-bit frequency, 12-bit amplitude, 14-bit phase control
// - frequency, amplitude and phase writes accepted on the fly
// - tuning word two, phase adjust two, offset, sweep gated by mode
// - keying, amplitude, inverse sinc, tuning word one in all modes
// - differential reference input when select high, single-ended low
// - fsk mode: pin low picks tuning word one, high picks word two
module synth_mode_select_single_tone import synth_pkg::*; (
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    // apb slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [DATA_W-1:0] PWDATA,
    output logic      [DATA_W-1:0] PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // device pins
    input  wire logic              PARALLEL_SEL,
    input  wire logic              DIFF_REF_CLOCK_IN_SELECT,
    input  wire logic              FSK_PIN,
    // programming port configuration
    output logic                   PAR_IF_ACTIVE,
    output logic                   SER_IF_ACTIVE,
    output logic                   SER_LSB_FIRST,
    output logic                   SERIAL_OUT_PIN_EN,
    output logic                   SDIO_BIDIR_EN,
    // reference clock input selection
    output logic                   REF_CLOCK_IN_EN,
    output logic                   REF_CLOCK_IN_COMP_EN,
    // mode and function gating
    output logic      [4:0]        MODE_ACTIVE,
    output caps_t                  FUNC_ENABLE,
    // synthesis outputs
    output logic      [PHS_W-1:0]  PHASE_OUT,
    output logic      [AMP_W-1:0]  DAC_I,
    output logic      [AMP_W-1:0]  DAC_Q
);
    typedef struct packed {
        logic [2:0]        mode_code;
        logic              lsb_first;
        logic              rb_dedicate;
        logic [ACC_W-1:0]  tune_word_one;
        logic [ACC_W-1:0]  tune_word_two;
        logic [AMP_W-1:0]  ampl;
        logic [PHS_W-1:0]  padj1;
        logic [PHS_W-1:0]  padj2;
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
        mode_t             mode;
        caps_t             caps;
        logic              par_act;
        logic              ser_act;
        logic              lsb_out;
        logic              sdo_en;
        logic              sdio_en;
        logic              ref_en;
        logic              ref_comp_en;
        logic [ACC_W-1:0]  tw_sel;
        logic [PHS_W-1:0]  phase;
        logic [AMP_W-1:0]  dac_i;
        logic [AMP_W-1:0]  dac_q;
    } st_t;

    st_t st_q;
    st_t st_d;

    tune_if tun ();

    logic              setup_ph;
    logic              access_ph;
    logic              addr_ok;
    logic [DATA_W-1:0] rd_word;
    logic [PHS_W-1:0]  offset;
    logic [PHS_W-1:0]  ph_next;
    logic [AMP_W-2:0]  half_amp;

    // one setup edge, then access completes with no wait state
    assign setup_ph  = PSEL && !PENABLE;
    assign access_ph = PSEL && PENABLE && st_q.pready;

    // read mux: unmapped addresses answer zero and an error
    always_comb begin
        addr_ok = 1'b1;
        rd_word = WORD_ZERO;
        case (PADDR)
            ADDR_CTRL: begin
                rd_word[CTRL_MODE_LSB +: CTRL_MODE_W] = st_q.mode_code;
                rd_word[CTRL_LSBF_BIT]  = st_q.lsb_first;
                rd_word[CTRL_RBDED_BIT] = st_q.rb_dedicate;
            end
            ADDR_TW1_LO: rd_word = st_q.tune_word_one[DATA_W-1:0];
            ADDR_TW1_HI: rd_word[HI_W-1:0] = st_q.tune_word_one[ACC_W-1:DATA_W];
            ADDR_TW2_LO: rd_word = st_q.tune_word_two[DATA_W-1:0];
            ADDR_TW2_HI: rd_word[HI_W-1:0] = st_q.tune_word_two[ACC_W-1:DATA_W];
            ADDR_AMPL:   rd_word[AMP_W-1:0] = st_q.ampl;
            ADDR_PADJ1:  rd_word[PHS_W-1:0] = st_q.padj1;
            ADDR_PADJ2:  rd_word[PHS_W-1:0] = st_q.padj2;
            ADDR_STATUS: begin
                rd_word[STAT_MODE_LSB +: 5] = st_q.mode;
                rd_word[STAT_PAR_BIT]       = st_q.par_act;
                rd_word[STAT_DIFF_BIT]      = st_q.ref_comp_en;
                rd_word[STAT_CAPS_LSB +: $bits(caps_t)] = st_q.caps;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // phase offset: keyed pair in bpsk, plain offset elsewhere
    always_comb begin
        offset = PADJ_RST;
        if (st_q.caps.padj2 && FSK_PIN) begin
            offset = st_q.padj2;
        end else if (st_q.caps.padj1) begin
            offset = st_q.padj1;
        end
        ph_next  = tun.phase_top + offset;
        half_amp = st_q.ampl[AMP_W-1:1];
    end

    // next-state of the whole block
    always_comb begin
        st_d = st_q;
        // apb answer is captured in the setup cycle so outputs stay flops
        st_d.pready  = setup_ph;
        if (setup_ph) begin
            st_d.prdata  = PWRITE ? WORD_ZERO : rd_word;
            st_d.pslverr = !addr_ok;
        end else if (!PSEL) begin
            st_d.prdata  = WORD_ZERO;
            st_d.pslverr = 1'b0;
        end
        // writes land at the access edge, any time, any mode
        if (access_ph && PWRITE) begin
            case (PADDR)
                ADDR_CTRL: begin
                    st_d.mode_code   = PWDATA[CTRL_MODE_LSB +: CTRL_MODE_W];
                    st_d.lsb_first   = PWDATA[CTRL_LSBF_BIT];
                    st_d.rb_dedicate = PWDATA[CTRL_RBDED_BIT];
                end
                ADDR_TW1_LO: st_d.tune_word_one[DATA_W-1:0] = PWDATA;
                ADDR_TW1_HI: begin
                    st_d.tune_word_one[ACC_W-1:DATA_W] = PWDATA[HI_W-1:0];
                end
                ADDR_TW2_LO: st_d.tune_word_two[DATA_W-1:0] = PWDATA;
                ADDR_TW2_HI: begin
                    st_d.tune_word_two[ACC_W-1:DATA_W] = PWDATA[HI_W-1:0];
                end
                ADDR_AMPL:  st_d.ampl  = PWDATA[AMP_W-1:0];
                ADDR_PADJ1: st_d.padj1 = PWDATA[PHS_W-1:0];
                ADDR_PADJ2: st_d.padj2 = PWDATA[PHS_W-1:0];
                default: begin
                    st_d.mode_code = st_q.mode_code;
                end
            endcase
        end
        // mode decode; undefined codes fold to single tone
        st_d.mode = decode_mode(st_q.mode_code);
        st_d.caps = mode_caps(st_d.mode);
        // programming interface choice
        st_d.par_act = PARALLEL_SEL;
        st_d.ser_act = !PARALLEL_SEL;
        // serial-only bits are masked off in parallel mode
        st_d.lsb_out = !PARALLEL_SEL && st_q.lsb_first;
        st_d.sdo_en  = !PARALLEL_SEL && st_q.rb_dedicate;
        st_d.sdio_en = !PARALLEL_SEL && !st_q.rb_dedicate;
        // reference input selection
        st_d.ref_en      = 1'b1;
        st_d.ref_comp_en = DIFF_REF_CLOCK_IN_SELECT;
        // word two only where the mode allows it and the pin asks
        if (st_q.caps.tw2 && FSK_PIN) begin
            st_d.tw_sel = st_q.tune_word_two;
        end else begin
            st_d.tw_sel = st_q.tune_word_one;
        end
        // square approximation around midscale; zero amplitude holds mid
        st_d.phase = ph_next;
        st_d.dac_i = ph_next[PHS_W-1] ? DAC_MID - {1'b0, half_amp}
                                      : DAC_MID + {1'b0, half_amp};
        st_d.dac_q = (ph_next[PHS_W-1] ^ ph_next[PHS_W-2])
                   ? DAC_MID - {1'b0, half_amp}
                   : DAC_MID + {1'b0, half_amp};
    end

    // reset defaults give 0 Hz and no output until programmed
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_q               <= '0;
            st_q.mode          <= MODE_SINGLE;
            st_q.caps          <= mode_caps(MODE_SINGLE);
            st_q.tune_word_one <= TW_RST;
            st_q.tune_word_two <= TW_RST;
            st_q.ampl          <= AMPL_RST;
            st_q.dac_i         <= DAC_MID;
            st_q.dac_q         <= DAC_MID;
            st_q.ref_en        <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign tun.tuning_word = st_q.tw_sel;

    phase_core #(
        .W (ACC_W)
    ) u_core (
        .CLK     (CLK),
        .SYS_RST (SYS_RST),
        .tun     (tun.core)
    );

    // outputs straight from the state flops
    assign PRDATA               = st_q.prdata;
    assign PREADY               = st_q.pready;
    assign PSLVERR              = st_q.pslverr;
    assign PAR_IF_ACTIVE        = st_q.par_act;
    assign SER_IF_ACTIVE        = st_q.ser_act;
    assign SER_LSB_FIRST        = st_q.lsb_out;
    assign SERIAL_OUT_PIN_EN    = st_q.sdo_en;
    assign SDIO_BIDIR_EN        = st_q.sdio_en;
    assign REF_CLOCK_IN_EN      = st_q.ref_en;
    assign REF_CLOCK_IN_COMP_EN = st_q.ref_comp_en;
    assign MODE_ACTIVE          = st_q.mode;
    assign FUNC_ENABLE          = st_q.caps;
    assign PHASE_OUT            = st_q.phase;
    assign DAC_I                = st_q.dac_i;
    assign DAC_Q                = st_q.dac_q;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_setup;
        PSEL && !PENABLE;
    endsequence

    sequence s_access;
        PSEL && PENABLE && PREADY;
    endsequence

    a_apb_zero_wait: assert property (
        s_setup |=> PREADY ##1 !PREADY)
        else $error("apb access did not complete in one cycle");

    a_ampl_write: assert property (
        (s_access and (PWRITE && PADDR == ADDR_AMPL))
        |=> st_q.ampl == $past(PWDATA[AMP_W-1:0]))
        else $error("amplitude write not taken");

    a_if_select: assert property (
        PARALLEL_SEL |=> PAR_IF_ACTIVE && !SER_IF_ACTIVE)
        else $error("interface select does not follow the pin");

    a_serial_bits_gate: assert property (
        PAR_IF_ACTIVE |-> !SER_LSB_FIRST && !SERIAL_OUT_PIN_EN
                          && !SDIO_BIDIR_EN)
        else $error("serial control bits active in parallel mode");

    a_bit_order: assert property (
        (!PARALLEL_SEL && st_q.lsb_first) |=> SER_LSB_FIRST)
        else $error("lsb first not applied in serial mode");

    a_readback_pin: assert property (
        (!PARALLEL_SEL && st_q.rb_dedicate)
        |=> SERIAL_OUT_PIN_EN && !SDIO_BIDIR_EN)
        else $error("readback not dedicated to serial out pin");

    a_sdio_bidir: assert property (
        (!PARALLEL_SEL && !st_q.rb_dedicate)
        |=> SDIO_BIDIR_EN && !SERIAL_OUT_PIN_EN)
        else $error("data pin not bidirectional by default");

    a_undef_mode: assert property (
        (st_q.mode_code > CODE_BPSK) [*2] |-> MODE_ACTIVE == MODE_SINGLE)
        else $error("undefined mode code not single tone");

    a_fsk_word: assert property (
        (MODE_ACTIVE == MODE_FSK && FSK_PIN)
        |=> tun.tuning_word == $past(st_q.tune_word_two))
        else $error("fsk pin high did not pick word two");

    a_tw2_gated: assert property (
        !FUNC_ENABLE.tw2 |=> tun.tuning_word == $past(st_q.tune_word_one))
        else $error("word two used outside fsk modes");

    a_ref_clock_in_sel: assert property (
        DIFF_REF_CLOCK_IN_SELECT |=> REF_CLOCK_IN_COMP_EN && REF_CLOCK_IN_EN)
        else $error("differential input not enabled");

    a_midscale_hold: assert property (
        (st_q.ampl == AMPL_RST) [*2] |-> DAC_I == DAC_MID && DAC_Q == DAC_MID)
        else $error("dac left midscale at zero amplitude");
endmodule
`default_nettype wire

// *** tb/synth_host_model.sv ***
/*
 * apb host model that programs the synthesizer registers.
 * assumes the bench calls its task from one process at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module synth_host_model import synth_pkg::*; (
    // clock
    input  wire logic              clk,
    // apb master side
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic      [ADDR_W-1:0] paddr,
    output logic      [DATA_W-1:0] pwdata,
    input  wire logic [DATA_W-1:0] prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // one transfer; software hands over the rounded integer word and must
    // program the registers itself, since defaults give no tone
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // hold the request until pready is seen; only the watchdog ends it
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        // released lines show the inverse, not a stale copy
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// *** tb/synth_mode_select_single_tone_tb.sv ***
/*
 * self-checking bench for the mode selection and single-tone core.
 * assumes zero wait-state apb and one-cycle pin latency.
 */
`timescale 1ns/1ps
`default_nettype none
module synth_mode_select_single_tone_tb;
    import synth_pkg::*;
    logic              clk, sys_rst, par_sel, diff_sel, fsk_pin;
    logic              psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic              par_act, ser_act, lsb_first, sout_en, bidir_en;
    logic              ref_en, comp_en;
    logic [4:0]        mode_act;
    caps_t             caps;
    logic [PHS_W-1:0]  phase;
    logic [AMP_W-1:0]  dac_i, dac_q;
    int                bad_count = 0;
    int                total_checks = 0;
    logic [9:0]        caps_tab [5] = '{10'h0F9, 10'h1FD, 10'h3FD,
                                        10'h2FD, 10'h0EF};

    synth_mode_select_single_tone dut (.CLK(clk), .SYS_RST(sys_rst),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PARALLEL_SEL(par_sel),
        .DIFF_REF_CLOCK_IN_SELECT(diff_sel), .FSK_PIN(fsk_pin),
        .PAR_IF_ACTIVE(par_act), .SER_IF_ACTIVE(ser_act),
        .SER_LSB_FIRST(lsb_first), .SERIAL_OUT_PIN_EN(sout_en),
        .SDIO_BIDIR_EN(bidir_en), .REF_CLOCK_IN_EN(ref_en),
        .REF_CLOCK_IN_COMP_EN(comp_en), .MODE_ACTIVE(mode_act),
        .FUNC_ENABLE(caps), .PHASE_OUT(phase), .DAC_I(dac_i),
        .DAC_Q(dac_q));
    synth_host_model host (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // 25 MHz system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input string what, input logic [47:0] exp,
                       input logic [47:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        host.xfer(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] r,
                      output logic e);
        host.xfer(1'b0, a, 32'h0000_0000, r, e);
    endtask

    // settle a few cycles, then look off the edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // phase advance over one clock
    task automatic step(output logic [PHS_W-1:0] d);
        logic [PHS_W-1:0] p;
        p = phase;
        settle(1);
        d = phase - p;
    endtask

    task automatic t_reset;
        logic [31:0] r;
        logic        e;
        chk("mode", 5'h01, mode_act);
        chk("caps", 10'h0F9, caps);
        chk("dac_i", 12'h800, dac_i);
        chk("dac_q", 12'h800, dac_q);
        chk("ref_en", 1'b1, ref_en);
        rd(ADDR_TW1_LO, r, e);
        chk("tw1_lo", 32'h0000_0000, r);
        rd(ADDR_TW1_HI, r, e);
        chk("tw1_hi", 32'h0000_0000, r);
        chk("phase", 14'h0000, phase);
    endtask

    // rows: parallel, diff, ctrl, expected {par,ser,lsb,sout,bidir,comp}
    task automatic t_cfg;
        logic [13:0] tab [5] = '{14'b0_0_011000_011100, 14'b0_1_000000_010011,
            14'b0_0_001000_011010, 14'b1_1_011000_100001,
            14'b1_0_000000_100000};
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            par_sel <= tab[i][13];
            diff_sel <= tab[i][12];
            wr(ADDR_CTRL, {26'h0, tab[i][11:6]});
            settle(3);
            chk("port cfg", tab[i][5:0], {par_act, ser_act, lsb_first,
                sout_en, bidir_en, comp_en});
        end
    endtask

    task automatic t_modes;
        logic [31:0] r;
        logic        e;
        logic [4:0]  oh;
        logic [9:0]  c;
        for (int m = 0; m < 8; m++) begin
            oh = (m < 5) ? 5'(1 << m) : 5'h01;
            c = caps_tab[(m < 5) ? m : 0];
            wr(ADDR_CTRL, 32'(m));
            settle(3);
            chk("mode", oh, mode_act);
            chk("caps", c, caps);
            rd(ADDR_STATUS, r, e);
            chk("status", {c, 7'b0100000 | 7'(oh)}, {r[17:8], r[6:0]});
            rd(ADDR_CTRL, r, e);
            chk("ctrl", 32'(m), r);
        end
    endtask

    task automatic t_tone;
        logic [PHS_W-1:0] d;
        wr(ADDR_CTRL, 32'h0000_0000);
        wr(ADDR_TW1_LO, 32'h0000_0000);
        wr(ADDR_TW1_HI, 32'h0000_0004);
        settle(4);
        for (int i = 0; i < 4; i++) begin
            step(d);
            chk("advance", 14'h0001, d);
        end
        wr(ADDR_TW1_HI, 32'h0000_0008);
        for (int i = 0; i < 5; i++) begin
            step(d);
            chk("continuous", 1'b1, d == 14'h1 || d == 14'h2);
        end
        chk("new rate", 14'h0002, d);
        wr(ADDR_AMPL, 32'h0000_0FFE);
        settle(4);
        chk("dac swing", 1'b1, dac_i == 12'hFFF || dac_i == 12'h001);
        chk("dac q swing", 1'b1, dac_q == 12'hFFF || dac_q == 12'h001);
    endtask

    task automatic t_fsk;
        logic [PHS_W-1:0] d, p;
        wr(ADDR_TW2_LO, 32'h0000_0000);
        wr(ADDR_TW2_HI, 32'h0000_000C);
        fsk_pin <= 1'b1;
        settle(4);
        step(d);
        chk("tw2 ignored", 14'h0002, d);
        wr(ADDR_CTRL, {29'h0, CODE_FSK});
        settle(4);
        step(d);
        chk("fsk high", 14'h0003, d);
        @(posedge clk);
        fsk_pin <= 1'b0;
        settle(4);
        step(d);
        chk("fsk low", 14'h0002, d);
        // freeze the accumulator so only the keyed offset moves the phase
        wr(ADDR_TW1_HI, 32'h0000_0000);
        wr(ADDR_PADJ1, 32'h0000_0100);
        wr(ADDR_PADJ2, 32'h0000_2100);
        wr(ADDR_CTRL, {29'h0, CODE_BPSK});
        settle(4);
        p = phase;
        @(posedge clk);
        fsk_pin <= 1'b1;
        settle(3);
        chk("bpsk key", 14'h2000, 14'(phase - p));
    endtask

    task automatic t_unmapped;
        logic [31:0] r;
        logic        e;
        rd(8'h24, r, e);
        chk("bad rdata", 32'h0000_0000, r);
        chk("bad err", 1'b1, e);
        rd(ADDR_CTRL, r, e);
        chk("good err", 1'b0, e);
    endtask

    task automatic results;
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #(40 * 5000);
        bad_count++;
        results();
    end

    initial begin
        sys_rst = 1'b1;
        par_sel = 1'b0;
        diff_sel = 1'b0;
        fsk_pin = 1'b0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        settle(1);
        t_reset();
        t_cfg();
        t_modes();
        t_tone();
        t_fsk();
        t_unmapped();
        results();
    end
endmodule
`default_nettype wire
